//--- src/flash_dev_end.sv
// Flash end of the serial link: command decoder, buffers, page store and program engine.
`timescale 1ns/10ps
`include "flash_link_regs.svh"
// How it works
// - Flash launches on falling, samples on rising.
// - Host captures flash bits at next falling edge.
// - Host drives bits from rising edges.
// - Each rising edge after the first takes one bit, pipelined.
// - Chip select high before reset release.
// - 0BH, 03H, E8H read array continuously.
// - D2H reads one main page directly.
// - D4H, D6H read buffers fast.
// - D1H, D3H read buffers slow.
// - 32H, 35H, 77H read protection, lockdown, security.
// - D7H returns status, 9FH returns identification.
// - Host refreshes each page within 10,000 operations; host end raises rewriteDue at 2500 program frames and waits for 58H.
// - Host rewrites the page its pointer names; the flash end takes 58H and its address but copies nothing.
// - Program directly or via buffer then program.
// - Clock may idle low or high.
module flash_dev_end (
    // Serial link.
    spi_link_if.dev   link,
    // Core clock and reset for the program engine.
    input  wire logic core_clk,
    input  wire logic rst,
    // Engine state.
    output logic      busy,
    output logic      progDone
);
    import flash_link_pkg::*;

    logic [7:0] mainMem [0:255];
    logic [7:0] bufMem  [0:127];

    dev_link_t  lk_ff;
    dev_link_t  nxt_lk;
    dev_hold_t  hd_ff;
    dev_hold_t  nxt_hd;
    dev_core_t  co_ff;
    dev_core_t  nxt_co;
    cmd_info_t  info;
    cmd_info_t  newInfo;
    logic [7:0] inByte;
    logic [7:0] txByte;
    logic       bufWe;
    logic [6:0] bufWa;
    logic       memWe;
    logic       misoBit_ff;
    logic       misoOe_ff;
    logic       primed_ff;
    logic [31:0] idWord;

    assign idWord = `ID_WORD;

    // Byte the flash sends at the current data position.
    always_comb begin
        txByte = `PROT_RESET;
        case (lk_ff.opcode)
            `OP_CAR_FAST, `OP_CAR_SLOW, `OP_CAR_LEGACY: begin
                txByte = mainMem[lk_ff.ptr];
            end
            `OP_PAGE_READ: begin
                txByte = mainMem[{lk_ff.addr[7:6], lk_ff.ptr[5:0]}];
            end
            `OP_BUF1_READ, `OP_BUF1_READ_LF: begin
                txByte = bufMem[{1'b0, lk_ff.ptr[5:0]}];
            end
            `OP_BUF2_READ, `OP_BUF2_READ_LF: begin
                txByte = bufMem[{1'b1, lk_ff.ptr[5:0]}];
            end
            `OP_PROT_READ, `OP_LOCK_READ: begin
                txByte = `PROT_RESET;
            end
            `OP_SEC_READ: begin
                txByte = lk_ff.ptr;
            end
            `OP_STATUS_READ: begin
                txByte = {~hd_ff.busySync2, `STATUS_LOW};
            end
            `OP_ID_READ: begin
                txByte = (lk_ff.ptr[7:2] != 6'h00) ? 8'h00 :
                         idWord[8 * (3 - int'(lk_ff.ptr[1:0])) +: 8];
            end
            default: begin
                txByte = `PROT_RESET;
            end
        endcase
    end

    // Link-side decoder, one bit per rising edge.
    always_comb begin
        nxt_lk = lk_ff;
        nxt_hd = hd_ff;
        info = cmd_decode(lk_ff.opcode);
        inByte = {lk_ff.shIn, link.mosi};
        newInfo = cmd_decode(inByte);
        bufWe = 1'b0;
        bufWa = {info.bufSel, lk_ff.ptr[5:0]};
        nxt_hd.busySync1 = co_ff.busy;
        nxt_hd.busySync2 = hd_ff.busySync1;
        nxt_lk.shIn = inByte[6:0];
        nxt_lk.bitCnt = lk_ff.bitCnt + 3'h1;
        if (lk_ff.bitCnt == 3'h7) begin
            case (lk_ff.phase)
                PH_CMD: begin
                    nxt_lk.opcode = inByte;
                    nxt_lk.phase = newInfo.needAddr ? PH_ADDR : PH_DATA;
                end
                PH_ADDR: begin
                    nxt_lk.addr = inByte;
                    nxt_lk.ptr = inByte;
                    nxt_lk.addrCnt = lk_ff.addrCnt + 2'h1;
                    if (lk_ff.addrCnt == 2'h2) begin
                        nxt_lk.dummyCnt = info.dummy;
                        nxt_lk.phase = (info.dummy != 3'h0) ? PH_DUMMY : PH_DATA;
                        if (info.isProg) begin
                            nxt_hd.progTgl = ~hd_ff.progTgl;
                            nxt_hd.progPage = inByte[7:6];
                            nxt_hd.progBuf = info.bufSel;
                        end
                    end
                end
                PH_DUMMY: begin
                    nxt_lk.dummyCnt = lk_ff.dummyCnt - 3'h1;
                    if (lk_ff.dummyCnt == 3'h1) begin
                        nxt_lk.phase = PH_DATA;
                    end
                end
                PH_DATA: begin
                    nxt_lk.ptr = lk_ff.ptr + 8'h01;
                    bufWe = info.isWrite;
                end
                default: begin
                    nxt_lk.phase = PH_CMD;
                end
            endcase
        end
        // The first rise of a frame only launches the host's first bit, so nothing is taken.
        if (!primed_ff) begin
            nxt_lk = '0;
        end
    end

    // A frame ends with chip select, so the link state clears on it.
    always_ff @(posedge link.sclk or posedge link.csN or negedge link.resetN) begin
        if (link.csN || !link.resetN) begin
            lk_ff <= '0;
            primed_ff <= 1'b0;
        end else begin
            lk_ff <= nxt_lk;
            primed_ff <= 1'b1;
        end
    end

    always_ff @(posedge link.sclk or negedge link.resetN) begin
        if (!link.resetN) begin
            hd_ff <= '0;
        end else begin
            hd_ff <= nxt_hd;
        end
    end

    always_ff @(posedge link.sclk) begin
        if (bufWe) begin
            bufMem[bufWa] <= inByte;
        end
    end

    // Output bits change only on falling edges, a whole period before capture.
    always_ff @(negedge link.sclk or posedge link.csN or negedge link.resetN) begin
        if (link.csN || !link.resetN) begin
            misoBit_ff <= 1'b0;
            misoOe_ff <= 1'b0;
        end else begin
            misoOe_ff <= (lk_ff.phase == PH_DATA) && info.isRead;
            misoBit_ff <= txByte[3'h7 - lk_ff.bitCnt];
        end
    end

    assign link.misoOut = misoBit_ff;
    assign link.misoOe = misoOe_ff;

    // Program engine: a program frame arms it, chip select rising starts the copy.
    always_comb begin
        nxt_co = co_ff;
        nxt_co.csSync1 = link.csN;
        nxt_co.csSync2 = co_ff.csSync1;
        nxt_co.csSync3 = co_ff.csSync2;
        nxt_co.tglSync1 = hd_ff.progTgl;
        nxt_co.tglSync2 = co_ff.tglSync1;
        nxt_co.progDone = 1'b0;
        memWe = 1'b0;
        if (co_ff.busy) begin
            memWe = 1'b1;
            nxt_co.copyIdx = co_ff.copyIdx + 6'h01;
            if (co_ff.copyIdx == 6'h3f) begin
                nxt_co.busy = 1'b0;
                nxt_co.progDone = 1'b1;
            end
        end else if (co_ff.csSync2 && !co_ff.csSync3 && co_ff.tglSync2 != co_ff.seenTgl) begin
            nxt_co.busy = 1'b1;
            nxt_co.seenTgl = co_ff.tglSync2;
            nxt_co.copyIdx = 6'h00;
            nxt_co.page = hd_ff.progPage;
            nxt_co.bufIdx = hd_ff.progBuf;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            co_ff <= '0;
            // Chip select idles high, so the synchroniser starts there and sees no false end.
            co_ff.csSync1 <= 1'b1;
            co_ff.csSync2 <= 1'b1;
            co_ff.csSync3 <= 1'b1;
        end else begin
            co_ff <= nxt_co;
        end
    end

    always_ff @(posedge core_clk) begin
        if (memWe) begin
            mainMem[{co_ff.page, co_ff.copyIdx}] <= bufMem[{co_ff.bufIdx, co_ff.copyIdx}];
        end
    end

    assign busy = co_ff.busy;
    assign progDone = co_ff.progDone;
endmodule : flash_dev_end

//--- src/flash_host_end.sv
// Host end of the serial link: reset sequencing, clock divider, frame engine, refresh pointer.
`timescale 1ns/10ps
`include "flash_link_regs.svh"
module flash_host_end (
    // Serial link.
    spi_link_if.host  link,
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rst,
    // Frame request.
    input  wire logic reqValid,
    output logic      reqReady,
    input  wire logic [7:0] reqOpcode,
    input  wire logic [7:0] reqAddr,
    input  wire logic [7:0] reqWrLen,
    input  wire logic [7:0] reqRdLen,
    input  wire logic modeIdleHigh,
    // Write data.
    input  wire logic [7:0] wrData,
    output logic      wrTake,
    // Read data.
    output logic [7:0] rdData,
    output logic      rdValid,
    // Page refresh.
    output logic      rewriteDue,
    output logic [7:0] rewriteAddr
);
    import flash_link_pkg::*;

    host_t      h_ff;
    host_t      nxt;
    cmd_info_t  info;
    cmd_info_t  cur;
    logic [8:0] addrEnd;
    logic [8:0] dumEnd;
    logic [8:0] txBytes;
    logic [7:0] txSel;

    always_comb begin
        nxt = h_ff;
        info = cmd_decode(reqOpcode);
        cur = cmd_decode(h_ff.opcode);
        addrEnd = cur.needAddr ? 9'h003 : 9'h000;
        dumEnd = addrEnd + 9'(cur.dummy);
        txBytes = 9'h001 + (info.needAddr ? 9'h003 : 9'h000) + 9'(info.dummy) + 9'(reqWrLen);
        txSel = 8'h00;
        if (h_ff.txIdx == 9'h000) begin
            txSel = h_ff.opcode;
        end else if (h_ff.txIdx == addrEnd) begin
            txSel = h_ff.addr;
        end else if (h_ff.txIdx > dumEnd) begin
            txSel = wrData;
        end
        nxt.misoS1 = link.miso;
        nxt.misoS2 = h_ff.misoS1;
        nxt.rdValid = 1'b0;
        nxt.wrTake = 1'b0;
        nxt.rewriteDue = h_ff.progCount >= 14'(`REWRITE_SPACING);
        case (h_ff.st)
            HS_RESET: begin
                nxt.cnt = h_ff.cnt + 9'h001;
                if (h_ff.cnt == 9'(`RST_CYC - 1)) begin
                    nxt.resetN = 1'b1;
                    nxt.cnt = 9'h000;
                    nxt.st = HS_RECOVER;
                end
            end
            HS_RECOVER: begin
                nxt.cnt = h_ff.cnt + 9'h001;
                if (h_ff.cnt == 9'(`REC_CYC - 1)) begin
                    nxt.sclk = modeIdleHigh;
                    nxt.reqReady = 1'b1;
                    nxt.st = HS_IDLE;
                end
            end
            HS_IDLE: begin
                nxt.sclk = modeIdleHigh;
                if (reqValid) begin
                    nxt.reqReady = 1'b0;
                    nxt.csN = 1'b0;
                    nxt.cpol = modeIdleHigh;
                    nxt.opcode = reqOpcode;
                    nxt.addr = reqAddr;
                    nxt.txBits = {1'b0, txBytes, 3'h0};
                    nxt.totBits = {1'b0, txBytes, 3'h0} + {2'h0, reqRdLen, 3'h0};
                    nxt.txIdx = 9'h000;
                    nxt.bitInByte = 3'h0;
                    nxt.rxBit = 3'h0;
                    nxt.rise = 13'h0000;
                    nxt.div = 2'h0;
                    nxt.cnt = 9'h000;
                    nxt.st = HS_LEAD;
                    if (reqOpcode == `OP_AUTO_REWRITE) begin
                        nxt.addr = {h_ff.pagePtr, 6'h00};
                        nxt.pagePtr = h_ff.pagePtr + 2'h1;
                        nxt.progCount = 14'h0000;
                    end else if (info.isProg && h_ff.progCount != 14'h3fff) begin
                        nxt.progCount = h_ff.progCount + 14'h0001;
                    end
                end
            end
            HS_LEAD: begin
                nxt.sclk = 1'b0;
                nxt.cnt = h_ff.cnt + 9'h001;
                if (h_ff.cnt == 9'h001) begin
                    nxt.st = HS_RUN;
                end
            end
            HS_RUN: begin
                nxt.div = h_ff.div + 2'h1;
                case (h_ff.div)
                    2'h0: begin
                        nxt.sclk = 1'b1;
                        nxt.rise = h_ff.rise + 13'h0001;
                    end
                    2'h1: begin
                        if (h_ff.rise <= h_ff.txBits) begin
                            nxt.bitInByte = h_ff.bitInByte + 3'h1;
                            nxt.mosi = h_ff.txSh[7];
                            nxt.txSh = {h_ff.txSh[6:0], 1'b0};
                            if (h_ff.bitInByte == 3'h0) begin
                                nxt.mosi = txSel[7];
                                nxt.txSh = {txSel[6:0], 1'b0};
                                nxt.txIdx = h_ff.txIdx + 9'h001;
                                nxt.wrTake = h_ff.txIdx > dumEnd;
                            end
                        end else begin
                            nxt.mosi = 1'b0;
                        end
                    end
                    2'h2: begin
                        nxt.sclk = 1'b0;
                        if (h_ff.rise >= h_ff.txBits + 13'h0002) begin
                            nxt.rxSh = {h_ff.rxSh[5:0], h_ff.misoS2};
                            nxt.rxBit = h_ff.rxBit + 3'h1;
                            if (h_ff.rxBit == 3'h7) begin
                                nxt.rdData = {h_ff.rxSh, h_ff.misoS2};
                                nxt.rdValid = 1'b1;
                            end
                        end
                        if (h_ff.rise == h_ff.totBits + 13'h0001) begin
                            nxt.st = HS_TAIL;
                        end
                    end
                    default: begin
                        nxt.div = 2'h0;
                    end
                endcase
            end
            HS_TAIL: begin
                nxt.sclk = h_ff.cpol;
                nxt.mosi = 1'b0;
                nxt.cnt = 9'h000;
                nxt.st = HS_GAP;
            end
            HS_GAP: begin
                nxt.csN = 1'b1;
                nxt.cnt = h_ff.cnt + 9'h001;
                if (h_ff.cnt == 9'(`CSHIGH_CYC)) begin
                    nxt.reqReady = 1'b1;
                    nxt.st = HS_IDLE;
                end
            end
            default: begin
                nxt.st = HS_RESET;
            end
        endcase
    end

    // Reset holds chip select high and pulls the flash reset low.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            h_ff <= '0;
            h_ff.csN <= 1'b1;
        end else begin
            h_ff <= nxt;
        end
    end

    assign link.csN = h_ff.csN;
    assign link.sclk = h_ff.sclk;
    assign link.mosi = h_ff.mosi;
    assign link.resetN = h_ff.resetN;
    assign reqReady = h_ff.reqReady;
    assign wrTake = h_ff.wrTake;
    assign rdData = h_ff.rdData;
    assign rdValid = h_ff.rdValid;
    assign rewriteDue = h_ff.rewriteDue;
    assign rewriteAddr = {h_ff.pagePtr, 6'h00};
endmodule : flash_host_end

//--- src/flash_link_pkg.sv
// Types and the opcode decoder shared by both link ends.
`include "flash_link_regs.svh"
package flash_link_pkg;
    typedef enum logic [1:0] {
        PH_CMD = 2'b00, PH_ADDR = 2'b01, PH_DUMMY = 2'b11, PH_DATA = 2'b10
    } link_phase_t;

    typedef enum logic [2:0] {
        HS_RESET = 3'b000, HS_RECOVER = 3'b001, HS_IDLE = 3'b011, HS_LEAD = 3'b010,
        HS_RUN = 3'b110, HS_TAIL = 3'b111, HS_GAP = 3'b101
    } host_state_t;

    typedef struct packed {
        logic       needAddr;
        logic [2:0] dummy;
        logic       isRead;
        logic       isWrite;
        logic       isProg;
        logic       bufSel;
    } cmd_info_t;

    typedef struct packed {
        link_phase_t phase;
        logic [2:0]  bitCnt;
        logic [6:0]  shIn;
        logic [7:0]  opcode;
        logic [7:0]  addr;
        logic [1:0]  addrCnt;
        logic [2:0]  dummyCnt;
        logic [7:0]  ptr;
    } dev_link_t;

    typedef struct packed {
        logic       progTgl;
        logic [1:0] progPage;
        logic       progBuf;
        logic       busySync1;
        logic       busySync2;
    } dev_hold_t;

    typedef struct packed {
        logic       csSync1;
        logic       csSync2;
        logic       csSync3;
        logic       tglSync1;
        logic       tglSync2;
        logic       seenTgl;
        logic       busy;
        logic       progDone;
        logic [5:0] copyIdx;
        logic [1:0] page;
        logic       bufIdx;
    } dev_core_t;

    typedef struct packed {
        host_state_t st;
        logic [8:0]  cnt;
        logic [1:0]  div;
        logic        sclk;
        logic        csN;
        logic        mosi;
        logic        resetN;
        logic        misoS1;
        logic        misoS2;
        logic        cpol;
        logic [7:0]  opcode;
        logic [7:0]  addr;
        logic [12:0] txBits;
        logic [12:0] totBits;
        logic [12:0] rise;
        logic [7:0]  txSh;
        logic [8:0]  txIdx;
        logic [2:0]  bitInByte;
        logic [6:0]  rxSh;
        logic [2:0]  rxBit;
        logic [7:0]  rdData;
        logic        rdValid;
        logic        wrTake;
        logic        reqReady;
        logic [13:0] progCount;
        logic [1:0]  pagePtr;
        logic        rewriteDue;
    } host_t;

    // Fields: needAddr, dummy bytes, read, buffer write, program, buffer select.
    function automatic cmd_info_t cmd_decode(input logic [7:0] op);
        cmd_info_t c;
        c = '0;
        case (op)
            `OP_CAR_FAST:      c = {1'b1, `DUMMY_CAR_FAST, 4'b1000};
            `OP_CAR_SLOW:      c = {1'b1, 3'h0, 4'b1000};
            `OP_CAR_LEGACY:    c = {1'b1, `DUMMY_CAR_LEGACY, 4'b1000};
            `OP_PAGE_READ:     c = {1'b1, `DUMMY_PAGE_READ, 4'b1000};
            `OP_BUF1_READ:     c = {1'b1, `DUMMY_BUF_READ, 4'b1000};
            `OP_BUF2_READ:     c = {1'b1, `DUMMY_BUF_READ, 4'b1001};
            `OP_BUF1_READ_LF:  c = {1'b1, 3'h0, 4'b1000};
            `OP_BUF2_READ_LF:  c = {1'b1, 3'h0, 4'b1001};
            `OP_PROT_READ,
            `OP_LOCK_READ,
            `OP_SEC_READ:      c = {1'b1, 3'h0, 4'b1000};
            `OP_STATUS_READ,
            `OP_ID_READ:       c = {1'b0, 3'h0, 4'b1000};
            `OP_BUF1_WRITE:    c = {1'b1, 3'h0, 4'b0100};
            `OP_BUF2_WRITE:    c = {1'b1, 3'h0, 4'b0101};
            `OP_BUF1_PROG:     c = {1'b1, 3'h0, 4'b0010};
            `OP_BUF2_PROG:     c = {1'b1, 3'h0, 4'b0011};
            `OP_PROG_VIA_BUF1: c = {1'b1, 3'h0, 4'b0110};
            `OP_PROG_VIA_BUF2: c = {1'b1, 3'h0, 4'b0111};
            `OP_AUTO_REWRITE:  c = {1'b1, 3'h0, 4'b0000};
            default:           c = '0;
        endcase
        return c;
    endfunction : cmd_decode
endpackage : flash_link_pkg

//--- src/flash_link_regs.svh
// Opcodes, fixed values and timing counts of the serial flash link.
`ifndef FLASH_LINK_REGS_SVH
`define FLASH_LINK_REGS_SVH
`define OP_CAR_FAST      8'h0b
`define OP_CAR_SLOW      8'h03
`define OP_CAR_LEGACY    8'he8
`define OP_PAGE_READ     8'hd2
`define OP_BUF1_READ     8'hd4
`define OP_BUF2_READ     8'hd6
`define OP_BUF1_READ_LF  8'hd1
`define OP_BUF2_READ_LF  8'hd3
`define OP_PROT_READ     8'h32
`define OP_LOCK_READ     8'h35
`define OP_SEC_READ      8'h77
`define OP_STATUS_READ   8'hd7
`define OP_ID_READ       8'h9f
`define OP_BUF1_WRITE    8'h84
`define OP_BUF2_WRITE    8'h87
`define OP_BUF1_PROG     8'h83
`define OP_BUF2_PROG     8'h86
`define OP_PROG_VIA_BUF1 8'h82
`define OP_PROG_VIA_BUF2 8'h85
`define OP_AUTO_REWRITE  8'h58
`define DUMMY_CAR_FAST   3'h1
`define DUMMY_CAR_LEGACY 3'h4
`define DUMMY_PAGE_READ  3'h4
`define DUMMY_BUF_READ   3'h1
// Identification bytes; the values are arbitrary.
`define ID_WORD          32'h5a3c0100
`define STATUS_LOW       7'h00
`define PROT_RESET       8'h00
`define CLK_PERIOD_NS    50
`define T_RST_NS         10000
`define RST_CYC          ((`T_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_REC_NS         1000
`define REC_CYC          ((`T_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_CSHIGH_NS      50
`define CSHIGH_CYC       ((`T_CSHIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REWRITE_LIMIT    10000
`define PAGE_COUNT       4
`define REWRITE_SPACING  (`REWRITE_LIMIT / `PAGE_COUNT)
`endif

//--- src/spi_link_if.sv
// Pin-level serial link between the flash end and the host end.
`timescale 1ns/10ps
interface spi_link_if;
    logic csN;
    logic sclk;
    logic mosi;
    logic resetN;
    logic misoOut;
    logic misoOe;
    logic miso;

    // The data-out wire floats high through a pull-up when the flash lets go.
    assign miso = misoOe ? misoOut : 1'b1;

    modport dev (input csN, input sclk, input mosi, input resetN,
                 output misoOut, output misoOe);
    modport host (output csN, output sclk, output mosi, output resetN, input miso);
endinterface : spi_link_if

//--- tb/flash_link_chk.sv
// Timing checks on the wires between the two link ends.
`timescale 1ns/10ps
module flash_link_chk (
    // Core clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Link wires.
    input wire logic csN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic resetN,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic miso
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_rstOrd; $rose(resetN) |-> csN && $past(csN); endproperty
    a_rstOrd: assert property (p_rstOrd) else $error("reset released while selected");
    property p_outFall; misoOe && $past(misoOe) && $changed(misoOut) |-> $fell(sclk); endproperty
    a_outFall: assert property (p_outFall) else $error("data out moved off a fall");
    property p_oeOn; $rose(misoOe) |-> $fell(sclk); endproperty
    a_oeOn: assert property (p_oeOn) else $error("data out enabled off a fall");
    property p_idleOff; csN && $past(csN) |-> !misoOe && miso; endproperty
    a_idleOff: assert property (p_idleOff) else $error("data out driven while idle");
    property p_inHold; $rose(sclk) && !csN |-> $stable(mosi); endproperty
    a_inHold: assert property (p_inHold) else $error("data in moved at a rise");
    property p_launch; !csN && !$past(csN) && $changed(mosi) |-> $past(sclk) && !$past(sclk, 2);
    endproperty
    a_launch: assert property (p_launch) else $error("data in launched off a rise");
    property p_idleClk; csN && $past(csN) && $changed(sclk) |=> $stable(sclk); endproperty
    a_idleClk: assert property (p_idleClk) else $error("clock moved while idle");
    property p_lead; $fell(csN) |-> ##3 $rose(sclk); endproperty
    a_lead: assert property (p_lead) else $error("first rise misplaced");
    property p_bitRate; $rose(sclk) ##1 !csN |-> ##1 $fell(sclk); endproperty
    a_bitRate: assert property (p_bitRate) else $error("clock high time wrong");
    c_mode3: cover property ($fell(csN) && sclk);
    c_read: cover property ($rose(misoOe));
    c_reset: cover property ($rose(resetN));
endmodule : flash_link_chk

//--- tb/tb.sv
// Both link ends joined; random traffic checked against a memory image.
`timescale 1ns/10ps
`include "flash_link_regs.svh"
module tb;
    import flash_link_pkg::*;
    logic       core_clk = 1'b0, rst = 1'b1, reqValid = 1'b0, modeIdleHigh = 1'b0;
    logic       reqReady, wrTake, rdValid, rewriteDue, busy, progDone, expBusy;
    logic [7:0] reqOpcode = 8'h00, reqAddr = 8'h00, reqWrLen = 8'h00, reqRdLen = 8'h00;
    logic [7:0] wrData = 8'h00, rdData, rewriteAddr;
    logic [7:0] mem [256], bufm [128], wq [$];
    logic [7:0] pOps [4] = '{8'h83, 8'h86, 8'h82, 8'h85};
    logic [7:0] rOps [8] = '{8'h0b, 8'h03, 8'he8, 8'hd2, 8'hd4, 8'hd6, 8'hd1, 8'hd3};
    logic [7:0] gOps [5] = '{8'h32, 8'h35, 8'h77, 8'h9f, 8'h00};
    int         mismatches = 0, checked = 0, doneCnt = 0;
    spi_link_if spi_link_if_i ();
    flash_dev_end flash_dev_end_i (.link(spi_link_if_i.dev), .core_clk(core_clk), .rst(rst),
        .busy(busy), .progDone(progDone));
    flash_host_end flash_host_end_i (.link(spi_link_if_i.host), .core_clk(core_clk), .rst(rst),
        .reqValid(reqValid), .reqReady(reqReady), .reqOpcode(reqOpcode), .reqAddr(reqAddr),
        .reqWrLen(reqWrLen), .reqRdLen(reqRdLen), .modeIdleHigh(modeIdleHigh),
        .wrData(wrData), .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid),
        .rewriteDue(rewriteDue), .rewriteAddr(rewriteAddr));
    flash_link_chk flash_link_chk_i (.core_clk(core_clk), .rst(rst), .csN(spi_link_if_i.csN),
        .sclk(spi_link_if_i.sclk), .mosi(spi_link_if_i.mosi), .resetN(spi_link_if_i.resetN),
        .misoOut(spi_link_if_i.misoOut), .misoOe(spi_link_if_i.misoOe),
        .miso(spi_link_if_i.miso));
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (progDone === 1'b1) begin
            doneCnt <= doneCnt + 1;
        end
    end
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            mismatches++;
        end
    endtask : chk
    task automatic tmo(input logic ok);
        if (!ok) begin
            $display("[ERR] wait expected done seen timeout");
            mismatches++;
            print_verdict();
        end
    endtask : tmo
    // Status bit 7 reads as ready, identification bytes follow the arbitrary word.
    function automatic logic [7:0] exp_byte(input logic [7:0] op, a, input int i);
        logic [7:0] s;
        s = a + 8'(i);
        case (op)
            8'h0b, 8'h03, 8'he8: return mem[s];
            8'hd2: return mem[{a[7:6], s[5:0]}];
            8'hd4, 8'hd1: return bufm[{1'b0, s[5:0]}];
            8'hd6, 8'hd3: return bufm[{1'b1, s[5:0]}];
            8'hd7: return expBusy ? 8'h00 : 8'h80;
            8'h9f: return i < 4 ? 8'(`ID_WORD >> (24 - 8 * i)) : 8'h00;
            8'h32, 8'h35: return 8'h00;
            8'h77: return s;
            default: return 8'hff;
        endcase
    endfunction : exp_byte
    task automatic fill(input logic sel);
        for (int j = 0; j < 64; j++) begin
            wq.push_back(8'($urandom));
            bufm[{sel, 6'(j)}] = wq[j];
        end
    endtask : fill
    task automatic frame(input logic [7:0] op, a, wl, rl);
        int n = 0;
        int k = 0;
        @(posedge core_clk);
        modeIdleHigh <= 1'($urandom);
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqOpcode <= op;
        reqAddr <= a;
        reqWrLen <= wl;
        reqRdLen <= rl;
        wrData <= wq.size() > 0 ? wq[0] : 8'h00;
        do begin
            @(posedge core_clk);
            k++;
        end while (!reqReady && k < 400);
        reqValid <= 1'b0;
        do begin
            @(posedge core_clk);
            k++;
            if (wrTake === 1'b1) begin
                void'(wq.pop_front());
                wrData <= wq.size() > 0 ? wq[0] : 8'h00;
            end
            if (rdValid === 1'b1) begin
                chk("rdData", rdData, exp_byte(op, a, n));
                n++;
            end
        end while (reqReady !== 1'b1 && k < 20000);
        tmo(k < 20000);
        chk("rdCount", 8'(n), rl);
    endtask : frame
    initial begin
        void'($urandom(32'h90be2cd5));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        chk("csN", 8'(spi_link_if_i.csN), 8'h01);
        chk("rewriteAddr", rewriteAddr, 8'h00);
        for (int b = 0; b < 2; b++) begin
            fill(b[0]);
            frame(b ? 8'h87 : 8'h84, 8'h00, 8'd64, 8'd0);
        end
        for (int p = 0; p < 4; p++) begin
            if (p > 1) begin
                fill(p[0]);
            end
            frame(pOps[p], {2'(p), 6'h00}, p > 1 ? 8'd64 : 8'd0, 8'd0);
            for (int j = 0; j < 64; j++) begin
                mem[{2'(p), 6'(j)}] = bufm[{p[0], 6'(j)}];
            end
            expBusy = 1'b1;
            frame(8'hd7, 8'h00, 8'd0, 8'd1);
            for (int k = 0; k < 400 && doneCnt <= p; k++) begin
                @(posedge core_clk);
            end
            tmo(doneCnt > p);
        end
        expBusy = 1'b0;
        frame(8'hd7, 8'h00, 8'd0, 8'd2);
        for (int t = 0; t < 16; t++) begin
            frame(rOps[t % 8], t < 8 ? 8'hfe : 8'($urandom), 8'd0, 8'(1 + $urandom % 6));
        end
        foreach (gOps[g]) begin
            frame(gOps[g], 8'($urandom), 8'd0, 8'd5);
        end
        frame(8'h58, rewriteAddr, 8'd0, 8'd0);
        chk("rewriteAddr", rewriteAddr, 8'h40);
        chk("rewriteDue", 8'(rewriteDue), 8'h00);
        print_verdict();
    end
endmodule : tb
